/* verilog/mspi_pkg.sv */
// constants and types for the master spi mode of the serial unit
// What this block does
// - both mode-select bits set to one enter master spi operation
// - parity and clock recovery are off in spi mode; receiver and transmitter keep separate enables
// - pin control and interrupt events behave alike in both modes
// - only master operation; serial clock always made internally
// - full duplex transfer over clock out, data out and data in
// - all four polarity and phase modes, as standard spi
// - bit order selectable, lsb first or msb first
// - transmit path double buffered, next byte queued during shifting
// - receive path holds two buffer levels beyond the shift register
// - no write collision flag; writes during transfer are queued while the buffer is empty, else dropped
// - no double speed bit; speed set only by the divider
// - serial clock rate is system clock over twice the sum of divider and one
// - divider is twelve bits over high and low parts, any value
// - interrupts follow the unit's own complete and empty events
// - shift out on one clock edge, sample on the opposite edge
// - each transfer starts when a byte is written to the data register
// - divider resets to zero for the fastest clock after reset
package mspi_pkg;
    localparam int DATA_W = 8;
    localparam int DIV_W = 12;
    localparam int DIV_HI_W = 4;
    localparam int BIT_CNT_W = 3;
    localparam logic [1:0] MODE_MSPI = 2'h3;
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_TRAIL = 2'b10
    } xfer_state_t;
endpackage

/* verilog/baud_divider.sv */
// baud divider that emits one-cycle enables for each serial clock half period
`timescale 1ns/10ps
`default_nettype none
module baud_divider (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic [mspi_pkg::DIV_W-1:0] div_i,
    output logic tick_o
);
    import mspi_pkg::*;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    wire terminal = (cnt_q == '0);
    // count down, reload at zero; each terminal count is one half period
    assign cnt_d = !run_i ? div_i : (terminal ? div_i : cnt_q - 12'h001);
    assign tick_o = run_i && terminal;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= DIV_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* verilog/pin_sync.sv */
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [2:0] sync_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_q <= 3'h0;
            level_o <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], pin_i};
            if (sync_q[1] == sync_q[2]) begin
                level_o <= sync_q[2];
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/usart_mspi.sv */
// serial unit in master spi mode: buffers, shifter, clock and event flags
`timescale 1ns/10ps
`default_nettype none
module usart_mspi (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] op_mode_select_i,
    input wire logic clock_polarity_bit_i,
    input wire logic clock_phase_bit_i,
    input wire logic bit_order_bit_i,
    input wire logic transmitter_enable_i,
    input wire logic receiver_enable_i,
    input wire logic clock_pin_direction_i,
    input wire logic baud_divider_high_wr_i,
    input wire logic [mspi_pkg::DIV_HI_W-1:0] baud_divider_high_i,
    input wire logic baud_divider_low_wr_i,
    input wire logic [7:0] baud_divider_low_i,
    input wire logic data_wr_i,
    input wire logic [mspi_pkg::DATA_W-1:0] data_wr_byte_i,
    input wire logic data_rd_i,
    input wire logic tx_complete_clr_i,
    input wire logic serial_data_in_i,
    output logic [mspi_pkg::DATA_W-1:0] data_rd_byte_o,
    output logic master_spi_mode_o,
    output logic data_empty_o,
    output logic tx_complete_o,
    output logic rx_complete_o,
    output logic data_overrun_o,
    output logic busy_o,
    output logic [mspi_pkg::DIV_W-1:0] baud_divider_o,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o
);
    import mspi_pkg::*;

    xfer_state_t state_q;
    xfer_state_t state_d;
    logic [DIV_W-1:0] div_q;
    logic [DATA_W-1:0] txbuf_q;
    logic txbuf_full_q;
    logic [DATA_W-1:0] tx_sh_q;
    logic [DATA_W-1:0] rx_sh_q;
    logic [BIT_CNT_W-1:0] bit_q;
    logic sck_q;
    logic dout_q;
    logic [DATA_W-1:0] rxbuf0_q;
    logic [DATA_W-1:0] rxbuf1_q;
    logic [1:0] rx_cnt_q;
    logic txc_q;
    logic ovr_q;
    logic din_s;
    logic tick;

    // mode decode; parity and recovery logic simply do not exist here
    wire spi_on = (op_mode_select_i == MODE_MSPI);
    wire run = spi_on && transmitter_enable_i;
    // clock idles at polarity level; data driven only when enabled
    wire idle_st = (state_q == ST_IDLE);
    wire load = idle_st && txbuf_full_q && run;
    wire lead_tick = tick && (state_q == ST_LEAD);
    wire trail_tick = tick && (state_q == ST_TRAIL);
    // phase 0 samples on the leading edge, phase 1 on the trailing edge
    wire sample_now = clock_phase_bit_i ? trail_tick : lead_tick;
    wire shift_now = clock_phase_bit_i ? lead_tick : trail_tick;
    wire last_bit = (bit_q == LAST_BIT);
    wire frame_done = trail_tick && last_bit;
    wire out_bit = bit_order_bit_i ? tx_sh_q[0] : tx_sh_q[DATA_W-1];
    wire [DATA_W-1:0] tx_next = bit_order_bit_i ? {1'b0, tx_sh_q[DATA_W-1:1]}
                                                : {tx_sh_q[DATA_W-2:0], 1'b0};
    wire [DATA_W-1:0] rx_next = bit_order_bit_i ? {din_s, rx_sh_q[DATA_W-1:1]}
                                                : {rx_sh_q[DATA_W-2:0], din_s};
    wire rx_store = frame_done && receiver_enable_i;
    wire rx_pop = data_rd_i && (rx_cnt_q != 2'h0);
    wire rx_full = (rx_cnt_q == 2'h2);
    // phase 1 puts its first bit out at the leading edge, not at reload
    wire first_setup = clock_phase_bit_i && lead_tick && (bit_q == '0);
    // phase 0 took its last sample on the leading edge already
    wire [DATA_W-1:0] rx_word = clock_phase_bit_i ? rx_next : rx_sh_q;

    baud_divider u_div (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(run && !idle_st),
        .div_i(div_q),
        .tick_o(tick)
    );

    pin_sync u_din_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(serial_data_in_i),
        .level_o(din_s)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (load) begin
                    state_d = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (!run) begin
                    state_d = ST_IDLE;
                end else if (tick) begin
                    state_d = ST_TRAIL;
                end
            end
            ST_TRAIL: begin
                if (!run) begin
                    state_d = ST_IDLE;
                end else if (tick) begin
                    // back-to-back frames when the buffer already holds a byte
                    state_d = (last_bit && !txbuf_full_q) ? ST_IDLE : ST_LEAD;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire reload = load || (frame_done && txbuf_full_q && run);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // divider halves written separately, any 12-bit value allowed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= DIV_RESET;
        end else begin
            if (baud_divider_high_wr_i) begin
                div_q[DIV_W-1:8] <= baud_divider_high_i;
            end
            if (baud_divider_low_wr_i) begin
                div_q[7:0] <= baud_divider_low_i;
            end
        end
    end

    // transmit buffer: a write while shifting queues if the buffer is empty and is dropped if full; no collision flag
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            txbuf_q <= DATA_RESET;
            txbuf_full_q <= 1'b0;
        end else begin
            if (data_wr_i && !txbuf_full_q && transmitter_enable_i) begin
                txbuf_q <= data_wr_byte_i;
                txbuf_full_q <= 1'b1;
            end else if (reload) begin
                txbuf_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_sh_q <= DATA_RESET;
            rx_sh_q <= DATA_RESET;
            bit_q <= '0;
            dout_q <= 1'b1;
        end else begin
            if (reload) begin
                tx_sh_q <= txbuf_q;
                bit_q <= '0;
                // in phase 1 the running frame's last bit must hold over its sample edge
                if (!clock_phase_bit_i) begin
                    dout_q <= bit_order_bit_i ? txbuf_q[0] : txbuf_q[DATA_W-1];
                end
            end else begin
                if (sample_now) begin
                    rx_sh_q <= rx_next;
                end
                if (first_setup) begin
                    dout_q <= out_bit;
                end else if (shift_now) begin
                    tx_sh_q <= tx_next;
                    dout_q <= bit_order_bit_i ? tx_sh_q[1] : tx_sh_q[DATA_W-2];
                end
                if (trail_tick) begin
                    bit_q <= bit_q + 3'h1;
                end
                if (idle_st && !txbuf_full_q) begin
                    dout_q <= 1'b1;
                end
            end
        end
    end

    // serial clock toggles at every divider tick, idling at polarity
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sck_q <= 1'b0;
        end else if (idle_st || !run) begin
            sck_q <= clock_polarity_bit_i;
        end else if (tick) begin
            sck_q <= ~sck_q;
        end
    end

    // two-level receive store; on overflow the newest byte is lost
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rxbuf0_q <= DATA_RESET;
            rxbuf1_q <= DATA_RESET;
            rx_cnt_q <= 2'h0;
            ovr_q <= 1'b0;
        end else begin
            if (rx_pop) begin
                rxbuf0_q <= rxbuf1_q;
            end
            if (rx_store && (!rx_full || rx_pop)) begin
                if (rx_cnt_q == 2'h0 || (rx_cnt_q == 2'h1 && rx_pop)) begin
                    rxbuf0_q <= rx_word;
                end else begin
                    rxbuf1_q <= rx_word;
                end
            end
            rx_cnt_q <= rx_cnt_q + {1'b0, rx_store && (!rx_full || rx_pop)}
                        - {1'b0, rx_pop};
            if (rx_store && rx_full && !rx_pop) begin
                ovr_q <= 1'b1;
            end else if (rx_pop) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // transmit complete: set wins over software clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            txc_q <= 1'b0;
        end else if (frame_done && !txbuf_full_q) begin
            txc_q <= 1'b1;
        end else if (tx_complete_clr_i) begin
            txc_q <= 1'b0;
        end
    end

    assign master_spi_mode_o = spi_on;
    assign data_rd_byte_o = rxbuf0_q;
    assign data_empty_o = !txbuf_full_q;
    assign tx_complete_o = txc_q;
    assign rx_complete_o = (rx_cnt_q != 2'h0);
    assign data_overrun_o = ovr_q;
    assign busy_o = !idle_st;
    assign baud_divider_o = div_q;
    // clock pin direction stays under software control, as in ordinary mode
    assign serial_clock_pin_oe_o = clock_pin_direction_i;
    assign serial_clock_pin_o = sck_q;
    assign serial_data_out_oe_o = run;
    assign serial_data_out_o = dout_q;
endmodule
`default_nettype wire

/* bench/usart_mspi_props.sv */
// port assertions for the master spi serial unit
`timescale 1ns/10ps
`default_nettype none
module usart_mspi_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] op_mode_select_i,
    input wire logic clock_polarity_bit_i,
    input wire logic transmitter_enable_i,
    input wire logic baud_divider_low_wr_i,
    input wire logic [7:0] baud_divider_low_i,
    input wire logic data_wr_i,
    input wire logic master_spi_mode_o,
    input wire logic data_empty_o,
    input wire logic tx_complete_o,
    input wire logic busy_o,
    input wire logic [mspi_pkg::DIV_W-1:0] baud_divider_o,
    input wire logic serial_clock_pin_o,
    input wire logic serial_data_out_oe_o
);
    import mspi_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic up_q, sclk_q;
    logic [DIV_W-1:0] gap_q;
    wire logic tog = serial_clock_pin_o != sclk_q;
    // gap_q counts cycles since the last clock pin change
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            up_q <= 1'b0;
            sclk_q <= 1'b0;
            gap_q <= '0;
        end else begin
            up_q <= 1'b1;
            sclk_q <= serial_clock_pin_o;
            gap_q <= tog ? '0 : gap_q + 1'b1;
        end
    end
    sequence s_take;
        data_wr_i && data_empty_o && transmitter_enable_i && master_spi_mode_o && !busy_o;
    endsequence
    sequence s_load;
        !data_empty_o ##1 (data_empty_o && busy_o);
    endsequence
    AST_MODE:
    assert property (master_spi_mode_o == (op_mode_select_i == MODE_MSPI)) else $error("mode");
    AST_DOE:
    assert property (serial_data_out_oe_o == (master_spi_mode_o && transmitter_enable_i))
        else $error("data out enable");
    AST_IDLE:
    assert property (up_q && master_spi_mode_o && !busy_o && !$past(busy_o)
        && $stable(clock_polarity_bit_i) |-> serial_clock_pin_o == clock_polarity_bit_i)
        else $error("idle clock level");
    AST_TAKE:
    assert property (s_take |=> s_load) else $error("write not loaded");
    AST_HALF:
    assert property (tog && busy_o && serial_clock_pin_o == clock_polarity_bit_i
        |-> gap_q == baud_divider_o) else $error("half period");
    AST_DLO:
    assert property (baud_divider_low_wr_i |=> baud_divider_o[7:0] == $past(baud_divider_low_i))
        else $error("divider low");
    AST_TXC:
    assert property ($fell(busy_o) |-> ##[0:2] tx_complete_o) else $error("tx complete");
    AST_RST:
    assert property ($past(sys_rst_i) |-> baud_divider_o == DIV_RESET) else $error("divider reset");
endmodule
bind usart_mspi usart_mspi_props i_props (.*);
`default_nettype wire

/* bench/spi_slave_model.sv */
// behavioural spi slave answering the serial unit
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic lsb_i,
    input wire logic sync_i,
    input wire logic [7:0] tx_i,
    output var logic miso_o,
    output var logic [7:0] rx_o,
    output var int frames_o
);
    logic s_q = 1'b0;
    int idx = 0;
    logic [7:0] sh = 8'h00;
    initial miso_o = 1'b1;
    initial frames_o = 0;
    function automatic logic pick(input int k);
        return lsb_i ? tx_i[k] : tx_i[7-k];
    endfunction
    // negedge sampling keeps clear of the unit's own register updates
    always @(negedge clk_i) begin
        if (sync_i) begin
            idx = 0;
            miso_o = pick(0);
        end else if (sclk_i !== s_q) begin
            if ((sclk_i != cpol_i) == !cpha_i) begin
                sh[lsb_i ? idx : 7-idx] = mosi_i;
                idx = idx + 1;
                if (idx == 8) begin
                    idx = 0;
                    rx_o = sh;
                    frames_o++;
                    if (!cpha_i) miso_o = pick(0);
                end
            end else miso_o = pick(idx);
        end
        s_q = sclk_i;
    end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// bench for the master spi serial unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mspi_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, sync = 1'b0;
    logic [1:0] op_mode_select_i = 2'h0;
    logic clock_polarity_bit_i = 1'b0, clock_phase_bit_i = 1'b0, bit_order_bit_i = 1'b0;
    logic transmitter_enable_i = 1'b0, receiver_enable_i = 1'b0, clock_pin_direction_i = 1'b0;
    logic baud_divider_high_wr_i = 1'b0, baud_divider_low_wr_i = 1'b0;
    logic [3:0] baud_divider_high_i = 4'h0;
    logic [7:0] baud_divider_low_i = 8'h00, data_wr_byte_i = 8'h00, data_rd_byte_o, srx;
    logic data_wr_i = 1'b0, data_rd_i = 1'b0, tx_complete_clr_i = 1'b0, serial_data_in_i;
    logic master_spi_mode_o, data_empty_o, tx_complete_o, rx_complete_o, data_overrun_o, busy_o;
    logic [DIV_W-1:0] baud_divider_o;
    logic serial_clock_pin_o, serial_clock_pin_oe_o, serial_data_out_o, serial_data_out_oe_o;
    logic [7:0] stx = 8'h00;
    int frames, mismatches = 0, n_tests = 0;
    usart_mspi i_dut (.*);
    spi_slave_model i_slave (.clk_i(clk_i), .sclk_i(serial_clock_pin_o),
        .mosi_i(serial_data_out_o), .cpol_i(clock_polarity_bit_i), .cpha_i(clock_phase_bit_i),
        .lsb_i(bit_order_bit_i), .sync_i(sync), .tx_i(stx), .miso_o(serial_data_in_i),
        .rx_o(srx), .frames_o(frames));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr_byte(input logic [7:0] b);
        @(posedge clk_i);
        data_wr_i <= 1'b1;
        data_wr_byte_i <= b;
        @(posedge clk_i);
        data_wr_i <= 1'b0;
    endtask
    task automatic set_div(input logic [11:0] d);
        @(posedge clk_i);
        {baud_divider_high_wr_i, baud_divider_low_wr_i} <= 2'h3;
        {baud_divider_high_i, baud_divider_low_i} <= d;
        @(posedge clk_i);
        {baud_divider_high_wr_i, baud_divider_low_wr_i} <= 2'h0;
        tick(1);
    endtask
    task automatic pop;
        data_rd_i <= 1'b1;
        tick(1);
        data_rd_i <= 1'b0;
        tick(2);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        tick(1);
        while ((busy_o !== 1'b0 || tx_complete_o !== 1'b1) && k < 1000) begin
            tick(1);
            k++;
        end
        if (k == 1000) begin
            mismatches++;
            tally_and_finish;
        end
        tick(2);
    endtask
    initial begin
        logic [7:0] b;
        logic [11:0] d;
        void'($urandom(32'hcdb7));
        tick(12);
        sys_rst_i <= 1'b0;
        tick(2);
        chk(baud_divider_o, DIV_RESET);
        chk(data_empty_o, 1);
        for (int i = 0; i < 4; i++) begin
            op_mode_select_i <= 2'(i);
            tick(2);
            chk(master_spi_mode_o, i == 3);
        end
        chk(serial_clock_pin_oe_o, 0);
        clock_pin_direction_i <= 1'b1;
        tick(1);
        {transmitter_enable_i, receiver_enable_i} <= 2'h3;
        set_div(12'ha5c);
        chk(baud_divider_o, 12'ha5c);
        chk(serial_clock_pin_oe_o, 1);
        chk(serial_data_out_oe_o, 1);
        for (int i = 0; i < 8; i++) begin
            {clock_polarity_bit_i, clock_phase_bit_i, bit_order_bit_i} <= 3'(i);
            d = 12'(4 + $urandom % 8);
            stx <= 8'($urandom);
            b = 8'($urandom);
            set_div(d);
            chk(baud_divider_o, d);
            tx_complete_clr_i <= 1'b1;
            sync <= 1'b1;
            tick(1);
            {tx_complete_clr_i, sync} <= 2'h0;
            tick(2);
            chk(tx_complete_o, 0);
            wr_byte(~b);
            tick(2);
            wr_byte(b);
            wr_byte(8'h5a);
            wait_done;
            chk(12'(frames), 12'(2 * i + 2));
            chk(srx, b);
            chk(rx_complete_o, 1);
            chk(data_rd_byte_o, stx);
            pop;
            chk(rx_complete_o, 1);
            chk(data_rd_byte_o, stx);
            pop;
            chk({rx_complete_o, data_overrun_o}, 0);
        end
        // three frames left unread keep two bytes and flag the lost third
        for (int j = 0; j < 4; j++) begin
            receiver_enable_i <= (j != 3);
            tx_complete_clr_i <= 1'b1;
            wr_byte(8'(j + 1));
            tx_complete_clr_i <= 1'b0;
            wait_done;
            chk(srx, 8'(j + 1));
            if (j == 2) begin
                chk(data_overrun_o, 1);
                chk(data_rd_byte_o, stx);
                pop;
                chk({rx_complete_o, data_overrun_o}, 2'h2);
                pop;
            end
        end
        chk(rx_complete_o, 0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
